// [hdl/sfc_crc_serial.sv]
// Purpose: bit serial crc, 8-bit default or 4-bit selectable
// Assumes: caller feeds message msb first, crc field as zeros
// Notes:   in 4-bit mode the upper nibble stays zero
`timescale 1ns/100ps
`include "sfc_consts.svh"
module sfc_crc_serial import sfc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    sfc_eng_if.crc eng
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;
    logic [7:0] seed;

    always_comb begin
        if (eng.mode4) begin
            seed = {4'h0, eng.seedSel};
        end else if (eng.seedSel == 4'h0) begin
            seed = `SFC_SEED_ALL;
        end else begin
            seed = {`SFC_SEED_HI, eng.seedSel};
        end
    end

    always_comb begin
        nxt_crc = crc_ff;
        if (eng.crcInit) begin
            nxt_crc = seed;
        end else if (eng.crcShift && eng.mode4) begin
            nxt_crc = {4'h0, crc_ff[2:0], eng.crcDin}
                ^ (crc_ff[3] ? {4'h0, `SFC_POLY4} : 8'h00);
        end else if (eng.crcShift) begin
            nxt_crc = {crc_ff[6:0], eng.crcDin}
                ^ (crc_ff[7] ? `SFC_POLY8 : 8'h00);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_ff <= `SFC_SEED_ALL;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign eng.crcVal = crc_ff;
endmodule : sfc_crc_serial

// [hdl/sfc_frame_host.sv]
// Purpose: host controller that frames commands for a sensor serial
//          port, appends the command crc and checks response crcs
// Assumes: software sets the configuration before writing a command
// Notes:   AXI4-Lite slave for software, one frame at a time
//
// What this block does
// - crc covers all 32 bits incl. field
// - bits enter crc msb first, as sent
// - load seed into crc low bits first
// - shift each bit into crc low end
// - eight zero bits follow message in default
// - default polynomial x8+x5+x3+x2+x+1
// - seed all ones, else 1111 plus field
// - configuration selects 4-bit crc formats
// - 4-bit register command field layout
// - 4-bit sensor command: zeros 27:4
// - 4-bit mode: x4+1, field as seed
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "sfc_consts.svh"
module sfc_frame_host import sfc_pkg::*; #(
    parameter int HALF_DIV = `SFC_HALF_DIV,
    parameter int NUM_SRC = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic spiClk,
    output logic spiMosi,
    output logic spiSelN,
    input wire logic spiMiso
);
    sfc_eng_if eng ();

    sfc_crc_serial u_crc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .eng(eng)
    );

    sfc_link_master #(.HALF_DIV(HALF_DIV)) u_link (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .eng(eng),
        .spiMiso(spiMiso),
        .spiClk(spiClk),
        .spiMosi(spiMosi),
        .spiSelN(spiSelN)
    );

    logic cfgMode4_ff;
    logic [3:0] cfgSeed_ff;
    logic [31:0] cmdReg_ff;
    logic [`SFC_IRQ_W-1:0] irqSt_ff, irqMsk_ff;
    logic crcOk_ff, irq_ff;

    logic awready_ff, wready_ff, bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff, rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;

    sfc_seq_t seq_ff;
    logic [4:0] bitCnt_ff;
    logic [31:0] shReg_ff, cmdWord_ff, txWord_ff, resp_ff;
    logic mode4_ff, launched_ff, linkStart_ff;
    logic [3:0] seed_ff;
    logic [3:0] lastCnt_ff [NUM_SRC];

    logic wrFire, rdFire, wrMapped, rdMapped;
    logic [31:0] wMask, nxt_cmd, cmdFmt, rdVal, fields;
    logic startReq, busy, crcGood, sensorResp;
    logic [2:0] srcId;
    logic [3:0] expCnt;
    logic [`SFC_IRQ_W-1:0] evSet, irqClr, nxt_irqSt;

    assign wrFire = s_axi_awvalid && awready_ff && s_axi_wvalid && wready_ff;
    assign rdFire = s_axi_arvalid && arready_ff;
    assign busy = (seq_ff != SEQ_IDLE);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wMask[8*i +: 8] = {8{s_axi_wstrb[i]}};
        end
    end

    always_comb begin
        if (s_axi_awaddr == `SFC_ADDR_CFG || s_axi_awaddr == `SFC_ADDR_CMD
                || s_axi_awaddr == `SFC_ADDR_IRQST
                || s_axi_awaddr == `SFC_ADDR_IRQMSK) begin
            wrMapped = 1'b1;
        end else begin
            wrMapped = 1'b0;
        end
    end

    // a command written while a frame runs is refused, never queued
    assign nxt_cmd = (cmdReg_ff & ~wMask) | (s_axi_wdata & wMask);
    assign startReq = wrFire && (s_axi_awaddr == `SFC_ADDR_CMD) && !busy;

    // command word with the crc field left zero for the trailing zeros
    always_comb begin
        if (nxt_cmd[`SFC_CMD_SENSOR]) begin
            cmdFmt = {nxt_cmd[31:28], 28'h0};
        end else begin
            cmdFmt = {nxt_cmd[31:28], 4'h0, nxt_cmd[23:8], 8'h00};
        end
    end

    // write channel: both ready together, response after both taken
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SFC_RESP_OK;
        end else if (wrFire) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            if (!wrMapped) begin
                bresp_ff <= `SFC_RESP_DECERR;
            end else if (s_axi_awaddr == `SFC_ADDR_CMD && busy) begin
                bresp_ff <= `SFC_RESP_SLVERR;
            end else begin
                bresp_ff <= `SFC_RESP_OK;
            end
        end else if (bvalid_ff) begin
            if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end else if (s_axi_awvalid && s_axi_wvalid && !awready_ff) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgMode4_ff <= 1'b0;
            cfgSeed_ff <= 4'h0;
            cmdReg_ff <= 32'h0;
            irqMsk_ff <= '0;
        end else if (wrFire) begin
            if (s_axi_awaddr == `SFC_ADDR_CFG) begin
                if (s_axi_wstrb[0]) begin
                    cfgMode4_ff <= s_axi_wdata[`SFC_CFG_MODE4];
                    cfgSeed_ff <= s_axi_wdata[`SFC_CFG_SEED_LSB +: 4];
                end
            end else if (s_axi_awaddr == `SFC_ADDR_CMD && !busy) begin
                cmdReg_ff <= nxt_cmd;
            end else if (s_axi_awaddr == `SFC_ADDR_IRQMSK) begin
                if (s_axi_wstrb[0]) begin
                    irqMsk_ff <= s_axi_wdata[`SFC_IRQ_W-1:0];
                end
            end
        end
    end

    // read side
    assign srcId = resp_ff[30:28];
    assign sensorResp = resp_ff[31];
    assign fields = {5'h0, resp_ff[27:26], srcId, resp_ff[7:4],
        resp_ff[9:8], resp_ff[13:10], resp_ff[25:14]};

    always_comb begin
        rdMapped = 1'b1;
        if (s_axi_araddr == `SFC_ADDR_CFG) begin
            rdVal = {24'h0, cfgSeed_ff, 3'h0, cfgMode4_ff};
        end else if (s_axi_araddr == `SFC_ADDR_CMD) begin
            rdVal = cmdReg_ff;
        end else if (s_axi_araddr == `SFC_ADDR_STAT) begin
            rdVal = {30'h0, crcOk_ff, busy};
        end else if (s_axi_araddr == `SFC_ADDR_RESP) begin
            rdVal = resp_ff;
        end else if (s_axi_araddr == `SFC_ADDR_FIELDS) begin
            rdVal = fields;
        end else if (s_axi_araddr == `SFC_ADDR_IRQST) begin
            rdVal = {29'h0, irqSt_ff};
        end else if (s_axi_araddr == `SFC_ADDR_IRQMSK) begin
            rdVal = {29'h0, irqMsk_ff};
        end else begin
            rdVal = 32'h0;
            rdMapped = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `SFC_RESP_OK;
            rdata_ff <= 32'h0;
        end else if (rdFire) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdVal;
            rresp_ff <= rdMapped ? `SFC_RESP_OK : `SFC_RESP_DECERR;
        end else if (rvalid_ff) begin
            if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end else if (s_axi_arvalid && !arready_ff) begin
            arready_ff <= 1'b1;
        end
    end

    // crc engine: seed reloads while idle and while the frame is sent
    assign eng.crcInit = (seq_ff == SEQ_IDLE) || (seq_ff == SEQ_SEND);
    assign eng.crcShift = (seq_ff == SEQ_TXCRC) || (seq_ff == SEQ_RXCRC);
    assign eng.crcDin = shReg_ff[31];
    assign eng.mode4 = mode4_ff;
    assign eng.seedSel = seed_ff;
    assign eng.linkStart = linkStart_ff;
    assign eng.txWord = txWord_ff;

    // residue check on the response; 4-bit mode keeps upper nibble zero
    assign crcGood = (eng.crcVal == 8'h00);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= SEQ_IDLE;
            bitCnt_ff <= 5'h00;
            shReg_ff <= 32'h0;
            cmdWord_ff <= 32'h0;
            txWord_ff <= 32'h0;
            resp_ff <= 32'h0;
            mode4_ff <= 1'b0;
            seed_ff <= 4'h0;
            launched_ff <= 1'b0;
            linkStart_ff <= 1'b0;
            crcOk_ff <= 1'b0;
        end else begin
            case (seq_ff)
                SEQ_IDLE: begin
                    mode4_ff <= cfgMode4_ff;
                    seed_ff <= cfgSeed_ff;
                    if (startReq) begin
                        shReg_ff <= cmdFmt;
                        cmdWord_ff <= cmdFmt;
                        bitCnt_ff <= 5'h00;
                        seq_ff <= SEQ_TXCRC;
                    end
                end
                SEQ_TXCRC: begin
                    // message bits, then the zeroed crc field positions
                    shReg_ff <= {shReg_ff[30:0], 1'b0};
                    bitCnt_ff <= bitCnt_ff + 5'h01;
                    if (bitCnt_ff == `SFC_LAST_BIT) begin
                        launched_ff <= 1'b0;
                        seq_ff <= SEQ_SEND;
                    end
                end
                SEQ_SEND: begin
                    if (!launched_ff) begin
                        if (mode4_ff) begin
                            txWord_ff <= {cmdWord_ff[31:4],
                                eng.crcVal[3:0]};
                        end else begin
                            txWord_ff <= {cmdWord_ff[31:8],
                                eng.crcVal};
                        end
                        linkStart_ff <= 1'b1;
                        launched_ff <= 1'b1;
                    end else begin
                        linkStart_ff <= 1'b0;
                        if (eng.linkDone) begin
                            shReg_ff <= eng.rxWord;
                            resp_ff <= eng.rxWord;
                            bitCnt_ff <= 5'h00;
                            seq_ff <= SEQ_RXCRC;
                        end
                    end
                end
                SEQ_RXCRC: begin
                    // whole response, crc field included
                    shReg_ff <= {shReg_ff[30:0], 1'b0};
                    bitCnt_ff <= bitCnt_ff + 5'h01;
                    if (bitCnt_ff == `SFC_LAST_BIT) begin
                        seq_ff <= SEQ_FIN;
                    end
                end
                default: begin
                    crcOk_ff <= crcGood;
                    seq_ff <= SEQ_IDLE;
                end
            endcase
        end
    end

    // per source message counters, only trusted frames update them
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    lastCnt_ff[g] <= `SFC_CNT_RST;
                end else if (seq_ff == SEQ_FIN && crcGood && mode4_ff
                        && sensorResp && srcId == 3'(g)) begin
                    lastCnt_ff[g] <= resp_ff[7:4];
                end
            end
        end
    endgenerate

    // wraps naturally after 1111
    assign expCnt = lastCnt_ff[srcId] + `SFC_CNT_STEP;

    always_comb begin
        evSet = '0;
        if (seq_ff == SEQ_FIN) begin
            evSet[`SFC_IRQ_DONE] = 1'b1;
            evSet[`SFC_IRQ_CRCERR] = !crcGood;
            evSet[`SFC_IRQ_CNTERR] = crcGood && mode4_ff && sensorResp
                && (resp_ff[7:4] != expCnt);
        end
    end

    assign irqClr = (wrFire && s_axi_awaddr == `SFC_ADDR_IRQST
        && s_axi_wstrb[0]) ? s_axi_wdata[`SFC_IRQ_W-1:0] : '0;
    // a new event in the clearing cycle survives
    assign nxt_irqSt = (irqSt_ff & ~irqClr) | evSet;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqSt_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irqSt_ff <= nxt_irqSt;
            irq_ff <= |(nxt_irqSt & irqMsk_ff);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign irq = irq_ff;
endmodule : sfc_frame_host

// [hdl/sfc_link_master.sv]
// Purpose: 32-bit full duplex serial master, clock idles low
// Assumes: device changes its output after the falling clock edge
// Notes:   input sampled through two flops at the end of the high half
`timescale 1ns/100ps
`include "sfc_consts.svh"
module sfc_link_master import sfc_pkg::*; #(
    parameter int HALF_DIV = `SFC_HALF_DIV
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    sfc_eng_if.link eng,
    input wire logic spiMiso,
    output logic spiClk,
    output logic spiMosi,
    output logic spiSelN
);
    sfc_link_t st_ff;
    logic misoMeta_ff, misoSync_ff;
    logic [7:0] div_ff;
    logic [4:0] bit_ff;
    logic [31:0] sh_ff, rx_ff;
    logic clk_ff, mosi_ff, sel_ff, done_ff;
    logic tick;

    assign tick = (div_ff == 8'(HALF_DIV - 1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            misoMeta_ff <= 1'b0;
            misoSync_ff <= 1'b0;
        end else begin
            misoMeta_ff <= spiMiso;
            misoSync_ff <= misoMeta_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 8'h00;
        end else if (st_ff == LNK_IDLE || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= LNK_IDLE;
            bit_ff <= 5'h00;
            sh_ff <= 32'h0;
            rx_ff <= 32'h0;
            clk_ff <= 1'b0;
            mosi_ff <= 1'b0;
            sel_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (st_ff)
                LNK_IDLE: begin
                    if (eng.linkStart) begin
                        sel_ff <= 1'b0;
                        sh_ff <= eng.txWord;
                        mosi_ff <= eng.txWord[31];
                        bit_ff <= 5'h00;
                        st_ff <= LNK_LOW;
                    end
                end
                LNK_LOW: begin
                    if (tick) begin
                        clk_ff <= 1'b1;
                        st_ff <= LNK_HIGH;
                    end
                end
                LNK_HIGH: begin
                    if (tick) begin
                        clk_ff <= 1'b0;
                        rx_ff <= {rx_ff[30:0], misoSync_ff};
                        if (bit_ff == `SFC_LAST_BIT) begin
                            st_ff <= LNK_HOLD;
                        end else begin
                            sh_ff <= {sh_ff[30:0], 1'b0};
                            mosi_ff <= sh_ff[30];
                            bit_ff <= bit_ff + 5'h01;
                            st_ff <= LNK_LOW;
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        sel_ff <= 1'b1;
                        done_ff <= 1'b1;
                        st_ff <= LNK_IDLE;
                    end
                end
            endcase
        end
    end

    assign spiClk = clk_ff;
    assign spiMosi = mosi_ff;
    assign spiSelN = sel_ff;
    assign eng.linkDone = done_ff;
    assign eng.rxWord = rx_ff;
endmodule : sfc_link_master

// [pkg/sfc_consts.svh]
// Purpose: offsets, field positions, reset values and counts of the
//          serial frame CRC host controller
// Assumes: included by bare name
// Notes:   definitions only
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_ADDR_CFG 8'h00
`define SFC_ADDR_CMD 8'h04
`define SFC_ADDR_STAT 8'h08
`define SFC_ADDR_RESP 8'h0c
`define SFC_ADDR_FIELDS 8'h10
`define SFC_ADDR_IRQST 8'h14
`define SFC_ADDR_IRQMSK 8'h18
`define SFC_CFG_MODE4 0
`define SFC_CFG_SEED_LSB 4
`define SFC_CMD_SENSOR 0
`define SFC_IRQ_DONE 0
`define SFC_IRQ_CRCERR 1
`define SFC_IRQ_CNTERR 2
`define SFC_IRQ_W 3
`define SFC_POLY8 8'h2f
`define SFC_POLY4 4'h1
`define SFC_SEED_ALL 8'hff
`define SFC_SEED_HI 4'hf
`define SFC_LAST_BIT 5'h1f
`define SFC_HALF_DIV 8
`define SFC_CNT_RST 4'h0
`define SFC_CNT_STEP 4'h1
`define SFC_RESP_OK 2'h0
`define SFC_RESP_SLVERR 2'h2
`define SFC_RESP_DECERR 2'h3
`endif

// [pkg/sfc_eng_if.sv]
// Purpose: joins the sequencer to the crc engine and the link shifter
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/100ps
interface sfc_eng_if;
    logic crcInit;
    logic crcShift;
    logic crcDin;
    logic mode4;
    logic [3:0] seedSel;
    logic [7:0] crcVal;
    logic linkStart;
    logic [31:0] txWord;
    logic linkDone;
    logic [31:0] rxWord;
    modport top (output crcInit, crcShift, crcDin, mode4, seedSel,
        linkStart, txWord, input crcVal, linkDone, rxWord);
    modport crc (input crcInit, crcShift, crcDin, mode4, seedSel,
        output crcVal);
    modport link (input linkStart, txWord, output linkDone, rxWord);
endinterface : sfc_eng_if

// [pkg/sfc_pkg.sv]
// Purpose: types of the serial frame CRC host controller
// Assumes: nothing
// Notes:   states are gray coded along the usual path, except SEQ_FIN to SEQ_IDLE
package sfc_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0, SEQ_TXCRC = 3'h1, SEQ_SEND = 3'h3,
        SEQ_RXCRC = 3'h2, SEQ_FIN = 3'h6
    } sfc_seq_t;
    typedef enum logic [1:0] {
        LNK_IDLE = 2'h0, LNK_LOW = 2'h1, LNK_HIGH = 2'h3, LNK_HOLD = 2'h2
    } sfc_link_t;
endpackage : sfc_pkg

// [test/sfc_frame_host_assertions.sv]
// Purpose: bus and link timing checks on the host's ports
// Assumes: single clock domain
// Notes: bound to every sfc_frame_host below
`timescale 1ns/100ps
module sfc_frame_host_assertions #(
    parameter int HALF_DIV = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic spiClk,
    input wire logic spiMosi,
    input wire logic spiSelN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    int hiCnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) hiCnt <= 0;
        else hiCnt <= spiClk ? hiCnt + 1 : 0;
    end
    chk_clk_idle: assert property (spiSelN |-> !spiClk)
        else $error("clock while deselected");
    chk_clk_high: assert property ($fell(spiClk) |-> hiCnt == HALF_DIV)
        else $error("clock high length");
    chk_mosi_fall: assert property (!spiSelN && $past(!spiSelN)
        && $changed(spiMosi) |-> $fell(spiClk))
        else $error("data off falling edge");
    chk_aw_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("write ready signals split");
    chk_write_ans: assert property (s_axi_awready && s_axi_awvalid
        |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_ans: assert property (s_axi_arready && s_axi_arvalid
        |=> s_axi_rvalid)
        else $error("read response late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
endmodule : sfc_frame_host_assertions
bind sfc_frame_host sfc_frame_host_assertions #(.HALF_DIV(HALF_DIV))
    sfc_frame_host_assertions_i (.*);

// [test/sfc_sensor_model.sv]
// Purpose: behavioural sensor end of the serial link
// Assumes: clock idles low, data sampled on rising edge
// Notes: answers in the same frame; released line shows inverse
`timescale 1ns/100ps
module sfc_sensor_model (
    input wire logic spiClk,
    input wire logic spiSelN,
    input wire logic spiMosi,
    output logic spiMiso,
    input wire logic mode4,
    input wire logic [3:0] seedSel,
    input wire logic [31:0] respBody,
    input wire logic badCrc,
    output logic [31:0] cmdWord,
    output logic cmdOk
);
    logic [31:0] tx = 32'h0;
    logic [31:0] rx = 32'h0;
    int n = 0;
    function automatic logic [7:0] crcOf(input logic [31:0] w);
        logic [7:0] c;
        c = (seedSel == 4'h0) ? 8'hff : {4'hf, seedSel};
        if (mode4) c = {4'h0, seedSel};
        for (int i = 31; i >= 0; i--) begin
            if (mode4) c = {4'h0, c[2:0], w[i] ^ c[3]};
            else c = {c[6:0], w[i]} ^ (c[7] ? 8'h2f : 8'h00);
        end
        return c;
    endfunction : crcOf
    initial {spiMiso, cmdWord, cmdOk} = 34'h0;
    always @(negedge spiSelN) begin
        tx = mode4 ? {respBody[31:4], 4'h0} : {respBody[31:8], 8'h0};
        tx[7:0] = tx[7:0] | crcOf(tx);
        tx[0] = tx[0] ^ badCrc;
        n = 31;
        spiMiso = tx[31];
    end
    always @(posedge spiClk) rx = {rx[30:0], spiMosi};
    always @(negedge spiClk) begin
        if (n > 0) begin
            n = n - 1;
            spiMiso = tx[n];
        end
        else spiMiso = ~spiMiso;
    end
    always @(posedge spiSelN) begin
        cmdWord = rx;
        cmdOk = (crcOf(rx) == 8'h00);
        spiMiso = ~spiMiso;
    end
endmodule : sfc_sensor_model

// [test/test_sfc_frame_host.sv]
// Purpose: register level bench of sfc_frame_host
// Assumes: HALF_DIV shortened to 3
// Notes: command crc words are fixed known answers
`timescale 1ns/100ps
`include "sfc_consts.svh"
module test_sfc_frame_host;
    logic ref_clk = 1'b0, rst_n = 1'b0, irq, spiClk, spiMosi, spiSelN;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, badCrc = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, spiMiso, mode4 = 1'b0, cmdOk;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, respBody = 32'h0;
    logic [31:0] s_axi_rdata, cmdWord, rv;
    logic [3:0] s_axi_wstrb = 4'hf, seedSel = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int err_count = 0, samples_checked = 0, cyc = 0;
    logic [31:0] vec [14] = '{32'h8022c1bd, 32'h401fc157, 32'hc0220066,
        32'h601fc1b8, 32'h40ff5ae5, 32'hc03e0013, 32'h60ff5a0a,
        32'h8022c10f, 32'h401fc10d, 32'hc0220006, 32'h601fc10f,
        32'h40ff5a01, 32'hc03e000b, 32'h60ff5a03};
    sfc_frame_host #(.HALF_DIV(3)) sfc_frame_host_i (.*);
    sfc_sensor_model sfc_sensor_model_i (.*);
    initial forever #2 ref_clk = ~ref_clk;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            tally_and_finish;
        end
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        cmp_word({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        cmp_word(rv, e);
    endtask : rdc
    task automatic setcfg(input logic m, input logic [3:0] s);
        wr(`SFC_ADDR_CFG, {24'h0, s, 3'h0, m}, `SFC_RESP_OK);
        mode4 <= m;
        seedSel <= s;
    endtask : setcfg
    task automatic run_frame(input logic [31:0] c);
        wr(`SFC_ADDR_CMD, c, `SFC_RESP_OK);
        do rd(`SFC_ADDR_STAT); while (rv[0] !== 1'b0);
    endtask : run_frame
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdc(`SFC_ADDR_CFG, 32'h0);
        rdc(`SFC_ADDR_IRQMSK, 32'h0);
        rdc(8'h1c, 32'h0);
        cmp_word({30'h0, rr}, {30'h0, `SFC_RESP_DECERR});
        wr(8'h1c, 32'h1, `SFC_RESP_DECERR);
        $display("reset test done");
        for (int i = 0; i < 14; i++) begin
            setcfg(i > 6, (i > 6) ? 4'ha : 4'h0);
            respBody <= vec[i] & 32'h7fffffff;
            run_frame(vec[i] & 32'hf0ffff00);
            cmp_word(cmdWord, vec[i]);
            rdc(`SFC_ADDR_STAT, 32'h2);
            rdc(`SFC_ADDR_RESP, sfc_sensor_model_i.tx);
        end
        setcfg(1'b0, 4'h5);
        run_frame(32'h40ff5a00);
        cmp_word({31'h0, cmdOk}, 32'h1);
        $display("crc table test done");
        cmp_word({31'h0, irq}, 32'h0);
        badCrc <= 1'b1;
        wr(`SFC_ADDR_IRQMSK, 32'h2, `SFC_RESP_OK);
        run_frame(32'h40ff5a00);
        rdc(`SFC_ADDR_STAT, 32'h0);
        rdc(`SFC_ADDR_IRQST, 32'h3);
        cmp_word({31'h0, irq}, 32'h1);
        wr(`SFC_ADDR_IRQST, 32'h2, `SFC_RESP_OK);
        rdc(`SFC_ADDR_IRQST, 32'h1);
        cmp_word({31'h0, irq}, 32'h0);
        badCrc <= 1'b0;
        $display("crc error test done");
        setcfg(1'b1, 4'h0);
        respBody <= {4'ha, 2'h1, 12'habc, 4'h5, 2'h2, 4'h1, 4'h0};
        run_frame(32'h80000001);
        cmp_word(cmdWord, 32'h80000008);
        rdc(`SFC_ADDR_FIELDS, {7'h1, 3'h2, 4'h1, 2'h2, 4'h5, 12'habc});
        rdc(`SFC_ADDR_IRQST, 32'h1);
        respBody <= {4'ha, 2'h1, 12'habc, 4'h5, 2'h2, 4'h3, 4'h0};
        run_frame(32'h80000001);
        rdc(`SFC_ADDR_IRQST, 32'h5);
        $display("sensor test done");
        tally_and_finish;
    end
endmodule : test_sfc_frame_host
